/* File: verilog/dil_interlock.v */
// guard-lock supervisor, forced door-opening mode, with Avalon-MM registers
// assumes pins are asynchronous; one 100 MHz clock, synchronous reset
//
// How it works
// R01 - mode active only with door present, forcing enabled
// R02 - high unlock request starts unlock sequence
// R03 - safe high only when closed and locked
// R04 - unlock drops safe at once, then releases
// R05 - drive solenoid after configurable unlock delay
// R06 - late lock feedback after drive change errors
// R07 - any error forces safe output low
// R08 - spring lock: de-energised means locked
// R09 - door must really open after unlock
// R10 - relock when released and door closed, or at once on late feedback or with the mode switched off
// R11 - safe returns after lock and door confirmed
// R12 - no opening in cycle raises error
// R13 - user keeps timeout above solenoid time
// R14 - error output only when enabled
`timescale 1ns/1ns
`default_nettype none
`include "dil_defines.vh"
module dil_interlock #(
    parameter [26:0] UNLOCK_CYC = `DIL_UNLOCK_CYC,
    parameter [26:0] FBK_CYC = `DIL_FBK_CYC
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire unlockReq,
    input wire lockFbk,
    input wire doorClosed,
    output reg lock_solenoid_drive,
    output reg solenoid_active_trace,
    output reg safeOut,
    output reg errorOut,
    output reg irqOut,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest
);
    // ==========================================================
    // states
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_DELAY = 3'd1;
    localparam [2:0] ST_OPEN = 3'd2;
    localparam [2:0] ST_RELOCK = 3'd3;
    localparam [2:0] ST_FAULT = 3'd4;

    // ==========================================================
    // input synchronisers
    wire reqS;
    wire fbkS;
    wire doorS;
    dil_sync uReq (.sys_clk(sys_clk), .sys_rst(sys_rst), .din(unlockReq), .dout(reqS));
    dil_sync uFbk (.sys_clk(sys_clk), .sys_rst(sys_rst), .din(lockFbk), .dout(fbkS));
    dil_sync uDoor (.sys_clk(sys_clk), .sys_rst(sys_rst), .din(doorClosed), .dout(doorS));

    // ==========================================================
    // registers
    reg [3:0] ctrl_r;
    reg [3:0] irq_r;
    reg [3:0] mask_r;
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [26:0] dlyCnt_r;
    reg [26:0] fbkCnt_r;
    reg fbkWait_r;
    reg fbkStart_r;
    reg drive_nxt;
    reg drive_r;
    reg opened_r;
    reg err_r;
    reg ackDone_r;
    // the synchronisers leave reset at zero, which reads as an open door;
    // door errors wait until the pin filters have seen the real levels
    reg [2:0] settle_r;
    wire settled = (settle_r == 3'h7);

    // R01 mode select
    wire modeOn = ctrl_r[`DIL_CTRL_DOOR] & ctrl_r[`DIL_CTRL_FORCE];
    wire spring = ctrl_r[`DIL_CTRL_SPRING];
    // R08 feedback reads energised; spring lock is engaged when not energised
    wire lockedNow = spring ? ~fbkS : fbkS;
    wire driveLvl = spring ? drive_r : ~drive_r;
    wire fbkMatch = (fbkS == driveLvl);
    wire doorOpenLocked = settled & ~doorS & lockedNow & ~drive_r;
    wire fbkLate = fbkWait_r & ~fbkMatch & (fbkCnt_r == FBK_CYC);
    wire noOpen = (state_r == ST_RELOCK) & lockedNow & ~opened_r;

    // ==========================================================
    // sequence
    always @* begin
        state_nxt = state_r;
        drive_nxt = drive_r;
        case (state_r)
            ST_IDLE: begin
                // R02 high request starts the sequence
                if (modeOn && reqS) begin
                    state_nxt = ST_DELAY;
                end
            end
            ST_DELAY: begin
                // R05 wait unlock delay
                if (dlyCnt_r >= UNLOCK_CYC) begin
                    state_nxt = ST_OPEN;
                    drive_nxt = 1'b1;
                end
            end
            ST_OPEN: begin
                // R10 relock when released and closed
                if (!reqS && doorS) begin
                    state_nxt = ST_RELOCK;
                    drive_nxt = 1'b0;
                end
            end
            ST_RELOCK: begin
                if (lockedNow && !fbkWait_r) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_FAULT: begin
                // a fault holds until released, door closed and lock engaged
                if (!reqS && doorS && lockedNow && !fbkWait_r) begin
                    state_nxt = ST_IDLE;
                end
                drive_nxt = 1'b0;
            end
            default: begin
                state_nxt = ST_IDLE;
                drive_nxt = 1'b0;
            end
        endcase
        if (fbkLate || !modeOn) begin
            state_nxt = modeOn ? ST_FAULT : ST_IDLE;
            drive_nxt = 1'b0;
        end
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            drive_r <= 1'b0;
            dlyCnt_r <= 27'h0;
            fbkCnt_r <= 27'h0;
            fbkWait_r <= 1'b0;
            fbkStart_r <= 1'b0;
            opened_r <= 1'b0;
            err_r <= 1'b0;
            settle_r <= 3'h0;
        end else begin
            if (!settled) begin
                settle_r <= settle_r + 3'h1;
            end
            state_r <= state_nxt;
            drive_r <= drive_nxt;
            dlyCnt_r <= (state_r == ST_DELAY) ? dlyCnt_r + 27'h1 : 27'h0;
            // R06 feedback timeout restarts on each drive change
            fbkStart_r <= (drive_nxt != drive_r);
            if (drive_nxt != drive_r) begin
                fbkWait_r <= 1'b1;
                fbkCnt_r <= 27'h0;
            end else if (fbkWait_r && fbkMatch) begin
                fbkWait_r <= 1'b0;
            end else if (fbkLate) begin
                fbkWait_r <= 1'b0;
            end else if (fbkWait_r) begin
                fbkCnt_r <= fbkCnt_r + 27'h1;
            end
            // R09 remember a real door opening
            if (state_r == ST_IDLE) begin
                opened_r <= 1'b0;
            end else if (drive_r && !doorS) begin
                opened_r <= 1'b1;
            end
            // R12 error latched at end of cycle without opening
            if (noOpen || fbkLate || doorOpenLocked) begin
                err_r <= 1'b1;
            end else if (state_r == ST_IDLE && reqS) begin
                err_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // outputs
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            lock_solenoid_drive <= 1'b0;
            solenoid_active_trace <= 1'b0;
            safeOut <= 1'b0;
            errorOut <= 1'b0;
        end else begin
            // R08 drive energises the solenoid to unlock
            lock_solenoid_drive <= drive_nxt;
            solenoid_active_trace <= drive_nxt;
            // R03 R04 R07 R11 safe only idle, closed, locked, error-free
            safeOut <= settled && modeOn && state_nxt == ST_IDLE && !reqS && doorS && lockedNow
                && !fbkWait_r && !err_r && !doorOpenLocked;
            // R14 error pin gated by enable
            errorOut <= ctrl_r[`DIL_CTRL_ERREN] & err_r;
        end
    end

    // ==========================================================
    // avalon slave: one wait cycle, then the answer
    wire acc = (avs_read | avs_write) & ~ackDone_r;
    wire [3:0] events = {reqS & (state_r == ST_IDLE) & modeOn, doorOpenLocked, noOpen, fbkLate};
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_r <= `DIL_CTRL_RST;
            irq_r <= 4'h0;
            mask_r <= 4'h0;
            ackDone_r <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
            irqOut <= 1'b0;
        end else begin
            ackDone_r <= acc;
            avs_waitrequest <= ~acc;
            irq_r <= (irq_r & ~((acc && avs_write && avs_address == `DIL_REG_IRQ) ? avs_writedata[3:0] : 4'h0))
                | events;
            if (acc && avs_write) begin
                if (avs_address == `DIL_REG_CTRL) begin
                    ctrl_r <= avs_writedata[3:0];
                end
                if (avs_address == `DIL_REG_MASK) begin
                    mask_r <= avs_writedata[3:0];
                end
            end
            if (acc && avs_read) begin
                case (avs_address)
                    `DIL_REG_CTRL: avs_readdata <= {28'h0, ctrl_r};
                    `DIL_REG_STAT: avs_readdata <= {23'h0, state_r, err_r, opened_r, safeOut, fbkS, doorS, drive_r};
                    `DIL_REG_IRQ: avs_readdata <= {28'h0, irq_r};
                    `DIL_REG_MASK: avs_readdata <= {28'h0, mask_r};
                    default: avs_readdata <= 32'h0;
                endcase
            end
            irqOut <= |(irq_r & mask_r);
        end
    end
endmodule // dil_interlock
`default_nettype wire

/* File: verilog/dil_defines.vh */
// constants for the door interlock forced-opening block
// assumes a 100 MHz sys_clk; times are given in ms and converted here
`ifndef DIL_DEFINES_VH
`define DIL_DEFINES_VH

`define DIL_CLK_MHZ 100
`define DIL_UNLOCK_MS 500
`define DIL_FBK_MS 100
`define DIL_UNLOCK_CYC (`DIL_UNLOCK_MS * 1000 * `DIL_CLK_MHZ)
`define DIL_FBK_CYC (`DIL_FBK_MS * 1000 * `DIL_CLK_MHZ)
`define DIL_CNT_W 27

// register offsets (byte addresses)
`define DIL_REG_CTRL 4'h0
`define DIL_REG_STAT 4'h4
`define DIL_REG_IRQ 4'h8
`define DIL_REG_MASK 4'hc

// control fields
`define DIL_CTRL_DOOR 0
`define DIL_CTRL_FORCE 1
`define DIL_CTRL_SPRING 2
`define DIL_CTRL_ERREN 3
`define DIL_CTRL_RST 4'hf

// irq bits
`define DIL_IRQ_FBK 0
`define DIL_IRQ_NOOPEN 1
`define DIL_IRQ_DOOR 2
`define DIL_IRQ_UNLOCK 3

`endif

/* File: verilog/dil_sync.v */
// three-stage input synchroniser with agreement filter
// assumes din is asynchronous to sys_clk
`timescale 1ns/1ns
`default_nettype none
module dil_sync (
    input wire sys_clk,
    input wire sys_rst,
    input wire din,
    output reg dout
);
    reg s1_r;
    reg s2_r;
    reg s3_r;
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // a change counts only once stages two and three agree
            if (s2_r == s3_r) begin
                dout <= s3_r;
            end
        end
    end
endmodule // dil_sync
`default_nettype wire

/* File: testbench/dil_door_model.sv */
// far side: lock solenoid with feedback contact and door sensor
// assumes spring lock: feedback high while the solenoid is energised
`timescale 1ns/1ns
`default_nettype none
module dil_door_model (
    input wire logic sys_clk,
    input wire logic lock_solenoid_drive,
    input wire logic openDoor,
    input wire logic stuck,
    output logic lockFbk,
    output logic doorClosed
);
    logic [2:0] dly_r = 3'h0;
    // ====================
    // solenoid and door
    // feedback lands well inside the timeout; stuck models a late one
    always @(posedge sys_clk) begin
        dly_r <= {dly_r[1:0], lock_solenoid_drive};
        if (!stuck)
            lockFbk <= dly_r[2];
    end
    assign doorClosed = !openDoor;
endmodule // dil_door_model
`default_nettype wire

/* File: testbench/dil_interlock_sva.sv */
// checker on the interlock pins and bus handshake
// assumes spring lock as set at reset
`timescale 1ns/1ns
`default_nettype none
module dil_interlock_sva #(parameter [26:0] UNLOCK_CYC = 27'h14, FBK_CYC = 27'ha) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic unlockReq,
    input wire logic lockFbk,
    input wire logic doorClosed,
    input wire logic lock_solenoid_drive,
    input wire logic solenoid_active_trace,
    input wire logic safeOut,
    input wire logic errorOut,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest
);
    // ====================
    // pin relations
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic [26:0] lowCnt_r;
    // cycles since safe dropped, so the unlock delay is seen from outside
    always @(posedge sys_clk)
        lowCnt_r <= (sys_rst || safeOut) ? 27'h0 : lowCnt_r + 27'h1;
    a_safe_locked: assert property (safeOut |-> !lockFbk) else $error("safe while unlocked");
    a_req_drop: assert property ($rose(unlockReq) |-> ##[1:8] !safeOut) else $error("safe kept");
    a_unlock_delay: assert property ($rose(lock_solenoid_drive) |-> lowCnt_r >= UNLOCK_CYC - 27'h2)
        else $error("early drive");
    a_trace_copy: assert property ($changed(lock_solenoid_drive) |-> ##[0:1]
        solenoid_active_trace == lock_solenoid_drive) else $error("trace differs");
    a_err_safe: assert property (errorOut |-> !safeOut) else $error("safe with error");
    a_relock_cond: assert property ($fell(lock_solenoid_drive) |-> !$past(unlockReq, 3) && $past(doorClosed, 3))
        else $error("bad relock");
    a_safe_return: assert property ($rose(safeOut) |-> $past(doorClosed, 3) && !$past(lockFbk, 3))
        else $error("early safe");
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
        else $error("no bus answer");
endmodule // dil_interlock_sva
bind dil_interlock dil_interlock_sva #(.UNLOCK_CYC(UNLOCK_CYC), .FBK_CYC(FBK_CYC)) chk_u (.*);
`default_nettype wire

/* File: testbench/door_interlock_forced_opening_tb_top.sv */
// self-checking bench: bus tasks and one task per scenario
// assumes the door model on the pins and short delay parameters
`timescale 1ns/1ns
`default_nettype none
module door_interlock_forced_opening_tb_top;
    logic sys_clk = 1'h0, sys_rst = 1'h1, unlockReq = 1'h0, openDoor = 1'h0, stuck = 1'h0;
    logic avs_read = 1'h0, avs_write = 1'h0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, rd;
    wire lockFbk, doorClosed, lock_solenoid_drive, solenoid_active_trace, safeOut, errorOut, irqOut, avs_waitrequest;
    wire [31:0] avs_readdata;
    wire [3:0] obs = {lockFbk, errorOut, lock_solenoid_drive, safeOut};
    int fails = 0, tests_run = 0, n;
    // short delays keep the run brief; the model answers in about 8 cycles
    dil_interlock #(.UNLOCK_CYC(27'h14), .FBK_CYC(27'h1e)) dut_u (.*);
    dil_door_model door_u (.*);
    initial forever #5 sys_clk = ~sys_clk;
    // ====================
    // shared tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
        rd = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge sys_clk);
    endtask
    task waitv(input int s, input logic v);
        for (n = 0; n < 300 && obs[s] !== v; n++)
            @(posedge sys_clk);
    endtask
    task t_regs;
        bus(1'h0, 4'h0, 32'h0);
        chk(rd, 32'hf);
        bus(1'h1, 4'h2, 32'hffffffff);
        bus(1'h0, 4'h2, 32'h0);
        chk(rd, 32'h0);
        bus(1'h1, 4'hc, 32'hf);
        chk(safeOut, 1'h1);
        $display("regs done");
    endtask
    task t_cycle;
        unlockReq <= 1'h1;
        waitv(0, 1'h0);
        chk(n <= 8, 1'h1);
        waitv(1, 1'h1);
        chk(n >= 15 && n <= 25, 1'h1);
        waitv(3, 1'h1);
        openDoor <= 1'h1;
        repeat (9) @(posedge sys_clk);
        openDoor <= 1'h0;
        repeat (9) @(posedge sys_clk);
        chk(lock_solenoid_drive, 1'h1);
        unlockReq <= 1'h0;
        waitv(0, 1'h1);
        chk({errorOut, n < 40}, 2'h1);
        bus(1'h0, 4'h8, 32'h0);
        chk({irqOut, rd[3:0]}, 5'h18);
        bus(1'h1, 4'h8, 32'h8);
        repeat (2) @(posedge sys_clk);
        chk(irqOut, 1'h0);
        $display("unlock cycle done");
    endtask
    task t_noopen;
        unlockReq <= 1'h1;
        waitv(3, 1'h1);
        unlockReq <= 1'h0;
        waitv(2, 1'h1);
        chk({safeOut, n < 60}, 2'h1);
        bus(1'h0, 4'h8, 32'h0);
        chk(rd[1], 1'h1);
        bus(1'h1, 4'hc, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk(irqOut, 1'h0);
        bus(1'h1, 4'h0, 32'h7);
        repeat (2) @(posedge sys_clk);
        chk(errorOut, 1'h0);
        bus(1'h1, 4'h0, 32'hf);
        bus(1'h1, 4'h8, 32'hf);
        bus(1'h1, 4'hc, 32'hf);
        $display("no opening done");
    endtask
    task t_late;
        unlockReq <= 1'h1;
        waitv(3, 1'h1);
        openDoor <= 1'h1;
        repeat (9) @(posedge sys_clk);
        openDoor <= 1'h0;
        stuck <= 1'h1;
        unlockReq <= 1'h0;
        waitv(1, 1'h0);
        repeat (45) @(posedge sys_clk);
        bus(1'h0, 4'h8, 32'h0);
        chk({safeOut, rd[0]}, 2'h1);
        stuck <= 1'h0;
        $display("late feedback done");
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'h0;
        repeat (8) @(posedge sys_clk);
        t_regs;
        t_cycle;
        t_noopen;
        t_late;
        finish_test;
    end
    // the scenarios need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        fails++;
        finish_test;
    end
endmodule // door_interlock_forced_opening_tb_top
`default_nettype wire
